// ### capf_defs.svh
// Offsets, field positions, reset values and build-time defaults of the capability field bank.
`ifndef CAPF_DEFS_SVH
`define CAPF_DEFS_SVH

// Register byte offsets on the APB bus.
`define CAPF_OFS_MSIX_CTRL    8'h00
`define CAPF_OFS_MSIX_TABLE   8'h04
`define CAPF_OFS_MSIX_PENDING 8'h08
`define CAPF_OFS_PM_CAP       8'h0c
`define CAPF_OFS_PM_CSR       8'h10
`define CAPF_OFS_RESIZABLE_BAR_HDR     8'h14
`define CAPF_OFS_RESIZABLE_BAR_CAP0    8'h18
`define CAPF_OFS_RESIZABLE_BAR_CTRL0   8'h1c
`define CAPF_OFS_RESIZABLE_BAR_CAP1    8'h20
`define CAPF_OFS_RESIZABLE_BAR_CTRL1   8'h24
`define CAPF_OFS_WIN_SEL      8'h28
`define CAPF_OFS_WIN_DATA     8'h2c
`define CAPF_OFS_STATUS       8'h30

// Word indexes used by the decoder.
`define CAPF_FIELD_WORDS      6'd10
`define CAPF_IDX_WIN_SEL      6'd10
`define CAPF_IDX_WIN_DATA     6'd11
`define CAPF_IDX_STATUS       6'd12
`define CAPF_WIN_LIMIT        4'd10

// Field positions.
`define CAPF_PMC_LSB          16
`define CAPF_PM_NEXT_LSB      8
`define CAPF_PME_D3HOT_BIT    14
`define CAPF_PME_D1_BIT       12
`define CAPF_PME_D0_BIT       11
`define CAPF_D1_SUPPORT_BIT   9
`define CAPF_NO_SOFT_RST_BIT  3
`define CAPF_INDICATOR_LSB    0
`define CAPF_OFFSET_LSB       3
`define CAPF_RESIZABLE_BAR_NEXT_LSB    20
`define CAPF_RESIZABLE_BAR_VER_LSB     16
`define CAPF_RESIZABLE_BAR_COUNT_LSB   5
`define CAPF_RESIZABLE_BAR_SIZE_LSB    4
`define CAPF_RESIZABLE_BAR_EXT_ID      16'h0015

// Reset values.
`define CAPF_RST_WIN_SEL      4'h0
`define CAPF_RST_IGNORED      8'h00
`define CAPF_IGNORED_MAX      8'hff
`define CAPF_RST_RDATA        32'h0000_0000

// Build-time defaults.
`define CAPF_DEF_PM_ID        8'h01
`define CAPF_DEF_PM_NEXT      8'h00
`define CAPF_DEF_PM_VER       3'h3
`define CAPF_DEF_RESIZABLE_BAR_VER     4'h1
`define CAPF_DEF_RESIZABLE_BAR_NEXT    12'h000

`endif

// ### capf_pkg.sv
// Types shared by the capability field bank.
package capf_pkg;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [3:0]  window_sel;
        logic [7:0]  ignored_writes;
    } bank_state_t;

    typedef logic [31:0] cap_word_t;

endpackage

// ### msix_cap_fields.sv
// MSI-X locator and table size words, forced to zero while MSI-X is off.
`timescale 1ns/100ps
`include "capf_defs.svh"

module msix_cap_fields (
    input  wire logic               msix_enable,
    input  wire logic [10:0]        msix_table_size_cfg,
    input  wire logic [28:0]        msix_table_offset_cfg,
    input  wire logic [2:0]         msix_table_indicator_cfg,
    input  wire logic [28:0]        msix_pending_offset_cfg,
    input  wire logic [2:0]         msix_pending_indicator_cfg,
    output capf_pkg::cap_word_t     ctrl_word,
    output capf_pkg::cap_word_t     table_word,
    output capf_pkg::cap_word_t     pending_word
);

    always_comb begin
        ctrl_word    = '0;
        table_word   = '0;
        pending_word = '0;
        // RQ5: zero while disabled.
        if (msix_enable) begin
            // RQ4: size in bits 10..0.
            ctrl_word[10:0] = msix_table_size_cfg;
            // RQ3: table offset field.
            table_word[31:`CAPF_OFFSET_LSB] = msix_table_offset_cfg;
            // RQ2: table indicator field.
            table_word[2:`CAPF_INDICATOR_LSB] = msix_table_indicator_cfg;
            // RQ1: pending offset field.
            pending_word[31:`CAPF_OFFSET_LSB] = msix_pending_offset_cfg;
            pending_word[2:`CAPF_INDICATOR_LSB] = msix_pending_indicator_cfg;
        end
    end

endmodule // msix_cap_fields

// ### resizable_bar_cap_fields.sv
// Resizable BAR header, size and control words, all zero unless enabled.
`timescale 1ns/100ps
`include "capf_defs.svh"

module resizable_bar_cap_fields (
    input  wire logic               resize_bar_enable_cfg,
    input  wire logic [3:0]         resize_bar_version_cfg,
    input  wire logic [11:0]        resize_bar_next_pointer_cfg,
    input  wire logic [2:0]         resize_bar_count_cfg,
    input  wire logic [2:0]         resize_bar_index_first_cfg,
    input  wire logic [2:0]         resize_bar_index_second_cfg,
    input  wire logic [19:0]        resize_bar_sizes_first_cfg,
    input  wire logic [19:0]        resize_bar_sizes_second_cfg,
    output capf_pkg::cap_word_t     hdr_word,
    output capf_pkg::cap_word_t     cap0_word,
    output capf_pkg::cap_word_t     ctrl0_word,
    output capf_pkg::cap_word_t     cap1_word,
    output capf_pkg::cap_word_t     ctrl1_word
);

    always_comb begin
        hdr_word   = '0;
        cap0_word  = '0;
        ctrl0_word = '0;
        cap1_word  = '0;
        ctrl1_word = '0;
        // RQ16: present only when enabled.
        if (resize_bar_enable_cfg) begin
            // RQ17: 12-bit next offset.
            hdr_word[31:`CAPF_RESIZABLE_BAR_NEXT_LSB] = resize_bar_next_pointer_cfg;
            hdr_word[19:`CAPF_RESIZABLE_BAR_VER_LSB]  = resize_bar_version_cfg;
            hdr_word[15:0]                   = `CAPF_RESIZABLE_BAR_EXT_ID;
            // RQ20: sizes in 23..4, rest zero.
            cap0_word[23:`CAPF_RESIZABLE_BAR_SIZE_LSB] = resize_bar_sizes_first_cfg;
            cap1_word[23:`CAPF_RESIZABLE_BAR_SIZE_LSB] = resize_bar_sizes_second_cfg;
            // RQ18: count in bits 7..5.
            ctrl0_word[7:`CAPF_RESIZABLE_BAR_COUNT_LSB] = resize_bar_count_cfg;
            ctrl0_word[2:0] = resize_bar_index_first_cfg;
            // RQ21: second index zero.
            if (resize_bar_count_cfg > 3'd1) begin
                ctrl1_word[2:0] = resize_bar_index_second_cfg;
            end
        end
    end

endmodule // resizable_bar_cap_fields

// ### pcie_capability_field_config.sv
// APB register bank presenting the build-time capability fields of the endpoint.
//
// Function
// RQ1: Pending array offset is 29-bit build value.
// RQ2: Table indicator is 3-bit build value.
// RQ3: Table offset is 29-bit build value.
// RQ4: Table size drives message control bits 10..0.
// RQ5: MSI-X off zeroes all locator fields.
// RQ6: Vector table itself lives outside this block.
// RQ7: Power capability has 8-bit identifier.
// RQ8: Power capability has 8-bit next pointer.
// RQ9: Bit 14 set for PME from D3hot.
// RQ10: Bit 12 set for PME from D1.
// RQ11: Bit 11 set for PME from D0.
// RQ12: Bit 9 set for D1 support.
// RQ13: Power capability carries 3-bit version.
// RQ14: Control bit 3 reports no soft reset.
// RQ15: All functions report first function's power values.
// RQ16: Resizable BAR exists only when enabled.
// RQ17: Resizable BAR has 12-bit next offset.
// RQ18: BAR count sits in control bits 7..5.
// RQ19: First control register holds lowest index; the code places resize_bar_index_first_cfg unchecked.
// RQ20: Size vector 20 bits, edges read zero.
// RQ21: Second index zero for one or fewer.
// RQ22: Second index not below the first; the code passes resize_bar_index_second_cfg unchecked.
// RQ23: Fields are constants, writes cannot change them.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "capf_defs.svh"

module pcie_capability_field_config #(
    parameter logic        msix_enable_cfg             = 1'b1,
    parameter logic [10:0] msix_table_size_cfg         = 11'h000,
    parameter logic [28:0] msix_table_offset_cfg       = 29'h0000_0000,
    parameter logic [2:0]  msix_table_indicator_cfg    = 3'h0,
    parameter logic [28:0] msix_pending_offset_cfg     = 29'h0000_0000,
    parameter logic [2:0]  msix_pending_indicator_cfg  = 3'h0,
    parameter logic [7:0]  power_cap_identifier_cfg    = `CAPF_DEF_PM_ID,
    parameter logic [7:0]  power_cap_next_pointer_cfg  = `CAPF_DEF_PM_NEXT,
    parameter logic        pme_from_d3hot_cfg          = 1'b0,
    parameter logic        pme_from_d1_cfg             = 1'b0,
    parameter logic        pme_from_d0_cfg             = 1'b0,
    parameter logic        d1_state_support_cfg        = 1'b0,
    parameter logic [2:0]  power_spec_version_cfg      = `CAPF_DEF_PM_VER,
    parameter logic        no_soft_reset_cfg           = 1'b0,
    parameter logic        resize_bar_enable_cfg       = 1'b0,
    parameter logic [3:0]  resize_bar_version_cfg      = `CAPF_DEF_RESIZABLE_BAR_VER,
    parameter logic [11:0] resize_bar_next_pointer_cfg = `CAPF_DEF_RESIZABLE_BAR_NEXT,
    parameter logic [2:0]  resize_bar_count_cfg        = 3'h0,
    parameter logic [2:0]  resize_bar_index_first_cfg  = 3'h0,
    parameter logic [2:0]  resize_bar_index_second_cfg = 3'h0,
    parameter logic [19:0] resize_bar_sizes_first_cfg  = 20'h0_0000,
    parameter logic [19:0] resize_bar_sizes_second_cfg = 20'h0_0000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    capf_pkg::bank_state_t state_reg;
    capf_pkg::bank_state_t state_next;

    capf_pkg::cap_word_t   field_word [0:9];
    capf_pkg::cap_word_t   field_mask [0:9];
    logic [9:0]            field_hit;
    logic [9:0]            window_hit;
    logic [15:0]           pmc_value;
    logic [5:0]            word_index;
    logic                  addr_mapped;
    logic                  setup_phase;
    logic                  write_done;
    capf_pkg::cap_word_t   direct_data;
    capf_pkg::cap_word_t   window_data;
    capf_pkg::cap_word_t   read_data;

    // MSI-X locators and size.
    msix_cap_fields u_msix (
        .msix_enable                (msix_enable_cfg),
        .msix_table_size_cfg        (msix_table_size_cfg),
        .msix_table_offset_cfg      (msix_table_offset_cfg),
        .msix_table_indicator_cfg   (msix_table_indicator_cfg),
        .msix_pending_offset_cfg    (msix_pending_offset_cfg),
        .msix_pending_indicator_cfg (msix_pending_indicator_cfg),
        .ctrl_word                  (field_word[0]),
        .table_word                 (field_word[1]),
        .pending_word               (field_word[2])
    );

    // Resizable BAR structure.
    resizable_bar_cap_fields u_resizable_bar (
        .resize_bar_enable_cfg       (resize_bar_enable_cfg),
        .resize_bar_version_cfg      (resize_bar_version_cfg),
        .resize_bar_next_pointer_cfg (resize_bar_next_pointer_cfg),
        .resize_bar_count_cfg        (resize_bar_count_cfg),
        .resize_bar_index_first_cfg  (resize_bar_index_first_cfg),
        .resize_bar_index_second_cfg (resize_bar_index_second_cfg),
        .resize_bar_sizes_first_cfg  (resize_bar_sizes_first_cfg),
        .resize_bar_sizes_second_cfg (resize_bar_sizes_second_cfg),
        .hdr_word                    (field_word[5]),
        .cap0_word                   (field_word[6]),
        .ctrl0_word                  (field_word[7]),
        .cap1_word                   (field_word[8]),
        .ctrl1_word                  (field_word[9])
    );

    // Power management capabilities value; the single set of first-function
    // settings is shared by every function, so no per-function copy exists.
    always_comb begin
        pmc_value = '0;
        // RQ13: version field.
        pmc_value[2:0] = power_spec_version_cfg;
        // RQ12: D1 support bit.
        pmc_value[`CAPF_D1_SUPPORT_BIT] = d1_state_support_cfg;
        // RQ11: PME from D0.
        pmc_value[`CAPF_PME_D0_BIT] = pme_from_d0_cfg;
        // RQ10: PME from D1.
        pmc_value[`CAPF_PME_D1_BIT] = pme_from_d1_cfg;
        // RQ9: PME from D3hot.
        pmc_value[`CAPF_PME_D3HOT_BIT] = pme_from_d3hot_cfg;
    end

    // RQ7: identifier and RQ8 next pointer.
    assign field_word[3] = {pmc_value,
                            power_cap_next_pointer_cfg,
                            power_cap_identifier_cfg};

    // RQ14: no soft reset bit, RQ15 shared value.
    assign field_word[4] = {28'h000_0000, no_soft_reset_cfg, 3'h0};

    // Word decode and read muxing, one slice per field word.
    assign word_index = paddr[7:2];

    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : g_field
            assign field_hit[g]  = (word_index == 6'(g));
            assign window_hit[g] = (state_reg.window_sel == 4'(g));
            assign field_mask[g] = field_hit[g] ? field_word[g] : 32'h0000_0000;
        end
    endgenerate

    always_comb begin
        direct_data = '0;
        window_data = '0;
        for (int i = 0; i < 10; i++) begin
            direct_data = direct_data | field_mask[i];
            if (window_hit[i]) begin
                window_data = field_word[i];
            end
        end
    end

    // Unaligned or out-of-range addresses get an error answer.
    assign addr_mapped = (paddr[1:0] == 2'b00) && (word_index <= `CAPF_IDX_STATUS);

    always_comb begin
        case (word_index)
            `CAPF_IDX_WIN_SEL: begin
                read_data = {28'h000_0000, state_reg.window_sel};
            end
            `CAPF_IDX_WIN_DATA: begin
                read_data = window_data;
            end
            `CAPF_IDX_STATUS: begin
                read_data = {24'h00_0000, state_reg.ignored_writes};
            end
            default: begin
                read_data = (word_index < `CAPF_FIELD_WORDS) ? direct_data : 32'h0000_0000;
            end
        endcase
    end

    assign setup_phase = psel & ~penable;
    assign write_done  = psel & penable & state_reg.pready & ~state_reg.pslverr & pwrite;

    always_comb begin
        state_next         = state_reg;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
        // The answer is prepared in the setup cycle so the access phase
        // completes on its first edge with no wait state.
        if (setup_phase) begin
            state_next.pready  = 1'b1;
            state_next.pslverr = ~addr_mapped;
            state_next.prdata  = (pwrite || !addr_mapped) ? 32'h0000_0000 : read_data;
        end
        if (write_done) begin
            if (word_index == `CAPF_IDX_WIN_SEL) begin
                state_next.window_sel = pwdata[3:0];
            // RQ23: field writes ignored, counted.
            end else if (state_reg.ignored_writes != `CAPF_IGNORED_MAX) begin
                state_next.ignored_writes = state_reg.ignored_writes + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.prdata         <= `CAPF_RST_RDATA;
            state_reg.pready         <= 1'b0;
            state_reg.pslverr        <= 1'b0;
            state_reg.window_sel     <= `CAPF_RST_WIN_SEL;
            state_reg.ignored_writes <= `CAPF_RST_IGNORED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata  = state_reg.prdata;
    assign pready  = state_reg.pready;
    assign pslverr = state_reg.pslverr;

endmodule // pcie_capability_field_config

// ### pcie_capability_field_config_assertions.sv
// Bus timing and field shape assertions for the capability field bank.
`timescale 1ns/100ps
module cap_field_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire bad_addr = (paddr > 8'h30) || (paddr[1:0] != 2'b00);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd_at(logic [7:0] a);
        pready && !pwrite && !pslverr && (paddr == a);
    endsequence
    a_setup_gets_ready: assert property (s_setup |=> pready)
        else $error("no ready in the access cycle");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (s_setup ##0 bad_addr |=> pslverr && prdata == 32'h0)
        else $error("unmapped address not refused");
    a_mapped_no_err: assert property (s_setup ##0 !bad_addr |=> !pslverr)
        else $error("mapped address refused");
    a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("write returned data");
    a_size_field_only: assert property (s_rd_at(8'h00) |-> prdata[31:11] == 21'h0)
        else $error("table size word has stray bits");
    a_csr_bit_only: assert property (s_rd_at(8'h10) |-> (prdata & 32'hffff_fff7) == 32'h0)
        else $error("power csr has stray bits");
    a_size0_vec_edges: assert property (s_rd_at(8'h18) |->
        prdata[3:0] == 4'h0 && prdata[31:24] == 8'h00)
        else $error("first size vector edge bits set");
    a_size1_vec_edges: assert property (s_rd_at(8'h20) |->
        prdata[3:0] == 4'h0 && prdata[31:24] == 8'h00)
        else $error("second size vector edge bits set");
    a_ctrl1_index_only: assert property (s_rd_at(8'h24) |-> prdata[31:3] == 29'h0)
        else $error("second bar control word has stray bits");
    a_hdr_id_or_zero: assert property (s_rd_at(8'h14) |->
        prdata[15:0] == 16'h0015 || prdata == 32'h0)
        else $error("resizable bar header id wrong");
    a_count_field_pos: assert property (s_rd_at(8'h1c) |->
        prdata[31:8] == 24'h0 && prdata[4:3] == 2'h0)
        else $error("bar control word has stray bits");
    a_rdata_holds: assert property (pready ##1 !(psel && !penable) |-> $stable(prdata))
        else $error("read data changed before next setup");
endmodule // cap_field_checker

bind pcie_capability_field_config cap_field_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ### cfg_host_model.sv
// Configuration-space host model issuing APB transfers.
`timescale 1ns/100ps
module cfg_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The answer is taken at the very edge that samples pready high.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // cfg_host_model

// ### pcie_capability_field_config_tb_top.sv
// Self-checking bench for the capability field bank in three build variants.
`timescale 1ns/100ps
module pcie_capability_field_config_tb_top;
    logic        pclk, presetn, er;
    logic        psel_a, penable_a, pwrite_a, pready_a, pslverr_a;
    logic        psel_b, penable_b, pwrite_b, pready_b, pslverr_b;
    logic        psel_c, penable_c, pwrite_c, pready_c, pslverr_c;
    logic [7:0]  paddr_a, paddr_b, paddr_c;
    logic [31:0] pwdata_a, pwdata_b, prdata_a, prdata_b, rd;
    logic [31:0] pwdata_c, prdata_c;
    int          miscompares, tests_run;
    logic [31:0] exp_a [10] = '{32'h0000_05a3, 32'h091a_2b3a, 32'h055e_6f7d, 32'h4a03_4801,
        32'h0000_0008, 32'h1a01_0015, 32'h00ab_cde0, 32'h0000_0041, 32'h0012_3450, 32'h3};
    logic [31:0] exp_b [10] = '{32'h0, 32'h0, 32'h0, 32'h1005_4801, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0};
    logic [31:0] exp_c [10] = '{32'h0, 32'h0, 32'h0, 32'h0003_0001, 32'h0, 32'h0001_0015,
        32'h0, 32'h0000_0021, 32'h0, 32'h0};

    // Build-time settings of the three variants.
    localparam logic        set_true          = 1'b1;
    localparam logic        set_false         = 1'b0;
    localparam logic [10:0] size_a            = 11'h5a3;
    localparam logic [10:0] size_all_ones     = 11'h7ff;
    localparam logic [28:0] tbl_off_a         = 29'h0123_4567;
    localparam logic [28:0] pend_off_a        = 29'h00ab_cdef;
    localparam logic [28:0] off_all_ones      = 29'h1fff_ffff;
    localparam logic [2:0]  tbl_ind_a         = 3'h2;
    localparam logic [2:0]  pend_ind_a        = 3'h5;
    localparam logic [2:0]  ind_all_ones      = 3'h7;
    localparam logic [7:0]  pm_id             = 8'h01;
    localparam logic [7:0]  pm_next           = 8'h48;
    localparam logic [2:0]  pm_ver_a          = 3'h3;
    localparam logic [2:0]  pm_ver_b          = 3'h5;
    localparam logic [3:0]  bar_ver           = 4'h1;
    localparam logic [11:0] bar_next_a        = 12'h1a0;
    localparam logic [11:0] bar_next_all_ones = 12'hfff;
    localparam logic [2:0]  bar_count_two     = 3'h2;
    localparam logic [2:0]  bar_count_one     = 3'h1;
    localparam logic [2:0]  bar_idx_lo        = 3'h1;
    localparam logic [2:0]  bar_idx_hi        = 3'h3;
    localparam logic [19:0] sizes_a0          = 20'hab_cde;
    localparam logic [19:0] sizes_a1          = 20'h1_2345;
    localparam logic [19:0] sizes_all_ones    = 20'hf_ffff;
    logic [7:0]  bad [4] = '{8'h34, 8'hfc, 8'h01, 8'h2e};

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    pcie_capability_field_config #(
        .msix_table_size_cfg(size_a), .msix_table_offset_cfg(tbl_off_a),
        .msix_table_indicator_cfg(tbl_ind_a), .msix_pending_offset_cfg(pend_off_a),
        .msix_pending_indicator_cfg(pend_ind_a), .power_cap_identifier_cfg(pm_id),
        .power_cap_next_pointer_cfg(pm_next), .pme_from_d3hot_cfg(set_true),
        .pme_from_d0_cfg(set_true), .d1_state_support_cfg(set_true),
        .power_spec_version_cfg(pm_ver_a), .no_soft_reset_cfg(set_true),
        .resize_bar_enable_cfg(set_true), .resize_bar_version_cfg(bar_ver),
        .resize_bar_next_pointer_cfg(bar_next_a), .resize_bar_count_cfg(bar_count_two),
        .resize_bar_index_first_cfg(bar_idx_lo), .resize_bar_index_second_cfg(bar_idx_hi),
        .resize_bar_sizes_first_cfg(sizes_a0), .resize_bar_sizes_second_cfg(sizes_a1)
    ) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel_a), .penable(penable_a), .pwrite(pwrite_a),
        .paddr(paddr_a), .pwdata(pwdata_a), .prdata(prdata_a), .pready(pready_a),
        .pslverr(pslverr_a));

    pcie_capability_field_config #(
        .msix_enable_cfg(set_false), .msix_table_size_cfg(size_all_ones),
        .msix_table_offset_cfg(off_all_ones), .msix_table_indicator_cfg(ind_all_ones),
        .msix_pending_offset_cfg(off_all_ones), .msix_pending_indicator_cfg(ind_all_ones),
        .power_cap_identifier_cfg(pm_id), .power_cap_next_pointer_cfg(pm_next),
        .pme_from_d1_cfg(set_true), .power_spec_version_cfg(pm_ver_b),
        .resize_bar_enable_cfg(set_false), .resize_bar_next_pointer_cfg(bar_next_all_ones),
        .resize_bar_count_cfg(bar_count_two), .resize_bar_index_first_cfg(bar_idx_lo),
        .resize_bar_sizes_first_cfg(sizes_all_ones)
    ) DUT2 (
        .pclk(pclk), .presetn(presetn), .psel(psel_b), .penable(penable_b), .pwrite(pwrite_b),
        .paddr(paddr_b), .pwdata(pwdata_b), .prdata(prdata_b), .pready(pready_b),
        .pslverr(pslverr_b));

    // A single resizable BAR: the second control word must read zero.
    pcie_capability_field_config #(
        .resize_bar_enable_cfg(set_true), .resize_bar_count_cfg(bar_count_one),
        .resize_bar_index_first_cfg(bar_idx_lo), .resize_bar_index_second_cfg(bar_idx_hi)
    ) DUT3 (
        .pclk(pclk), .presetn(presetn), .psel(psel_c), .penable(penable_c), .pwrite(pwrite_c),
        .paddr(paddr_c), .pwdata(pwdata_c), .prdata(prdata_c), .pready(pready_c),
        .pslverr(pslverr_c));

    cfg_host_model h_a (.pclk(pclk), .psel(psel_a), .penable(penable_a), .pwrite(pwrite_a),
        .paddr(paddr_a), .pwdata(pwdata_a), .prdata(prdata_a), .pready(pready_a),
        .pslverr(pslverr_a));
    cfg_host_model h_b (.pclk(pclk), .psel(psel_b), .penable(penable_b), .pwrite(pwrite_b),
        .paddr(paddr_b), .pwdata(pwdata_b), .prdata(prdata_b), .pready(pready_b),
        .pslverr(pslverr_b));
    cfg_host_model h_c (.pclk(pclk), .psel(psel_c), .penable(penable_c), .pwrite(pwrite_c),
        .paddr(paddr_c), .pwdata(pwdata_c), .prdata(prdata_c), .pready(pready_c),
        .pslverr(pslverr_c));

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    task automatic acc(input int s, input logic [7:0] a, input logic w, input logic [31:0] d);
        case (s)
            1: begin
                h_b.xfer(a, w, d, rd, er);
            end
            2: begin
                h_c.xfer(a, w, d, rd, er);
            end
            default: begin
                h_a.xfer(a, w, d, rd, er);
            end
        endcase
    endtask

    task automatic summarize();
        $display("counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        summarize();
    end

    initial begin
        presetn = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            acc(1'b0, 8'(4 * i), 1'b0, 32'h0);
            check(rd, exp_a[i]);
            acc(1'b1, 8'(4 * i), 1'b0, 32'h0);
            check(rd, exp_b[i]);
            acc(2, 8'(4 * i), 1'b0, 32'h0);
            check(rd, exp_c[i]);
        end
        $display("test field values done");
        for (int i = 0; i < 10; i++) begin
            acc(1'b0, 8'(4 * i), 1'b1, 32'hffff_ffff);
            check({31'h0, er}, 32'h0);
            acc(1'b0, 8'(4 * i), 1'b0, 32'h0);
            check(rd, exp_a[i]);
        end
        acc(1'b0, 8'h30, 1'b0, 32'h0);
        check(rd, 32'h0000_000a);
        $display("test read-only writes done");
        for (int i = 0; i <= 10; i++) begin
            acc(1'b0, 8'h28, 1'b1, 32'(i));
            acc(1'b0, 8'h28, 1'b0, 32'h0);
            check(rd, 32'(i));
            acc(1'b0, 8'h2c, 1'b0, 32'h0);
            check(rd, (i < 10) ? exp_a[i] : 32'h0);
        end
        $display("test window done");
        foreach (bad[k]) begin
            acc(1'b0, bad[k], k[0], 32'hffff_ffff);
            check({31'h0, er}, 32'h1);
            check(rd, 32'h0);
        end
        acc(1'b0, 8'h30, 1'b0, 32'h0);
        check(rd, 32'h0000_000a);
        $display("test unmapped done");
        summarize();
    end
endmodule // pcie_capability_field_config_tb_top
